// ---- sbce_pkg.sv ----
package sbce_pkg;
  // Datapath widths
  localparam int ACC_W = 56;
  localparam int WORD_W = 24;
  localparam int SR_W = 16;
  localparam int CTL_W = 8;
  localparam int CNT_W = 5;
  // Accumulator sign bit and its neighbour
  localparam int ACC_MSB = 55;
  localparam int ACC_NMSB = 54;
  // Opcode fields of and_immediate
  localparam logic [7:0] AND_IMMEDIATE_TOP = 8'h00;
  localparam logic [5:0] AND_IMMEDIATE_LOW = 6'h2E;
  localparam int IMM_LSB = 8;
  localparam logic [1:0] DST_MODE = 2'h0;
  localparam logic [1:0] DST_CCR = 2'h1;
  localparam logic [1:0] DST_OMR = 2'h2;
  // Opcode fields of the accumulator shifts
  localparam logic [3:0] ASL_CODE = 4'h3;
  localparam logic [3:0] ASR_CODE = 4'h2;
  localparam logic [2:0] SHIFT_LOW = 3'h2;
  localparam int SHIFT_ACC_BIT = 3;
  // Opcode fields of bit_test_complement
  localparam logic [7:0] BIT_TEST_COMPLEMENT_TOP = 8'h0B;
  localparam logic [1:0] BIT_TEST_COMPLEMENT_REG_FORM = 2'h3;
  localparam int BIT_TEST_COMPLEMENT_SPACE_BIT = 6;
  localparam logic [4:0] BIT_MAX = 5'h17;
  // Status register layout
  localparam int SR_C = 0;
  localparam int SR_V = 1;
  localparam int SR_Z = 2;
  localparam int SR_N = 3;
  localparam int SR_U = 4;
  localparam int SR_E = 5;
  localparam int SR_L = 6;
  localparam int SR_S0 = 10;
  localparam int SR_S1 = 11;
  localparam logic [SR_W-1:0] SR_IMPL = 16'hAF7F;
  localparam logic [SR_W-1:0] SR_RESET = 16'h0300;
  localparam logic [CTL_W-1:0] OMR_RESET = 8'h00;
  // Lowest bit that E looks at, and upper bit of the pair U compares, per scaling mode
  localparam int SCL_NONE = 47;
  localparam int SCL_DOWN = 48;
  localparam int SCL_UP = 46;
  // Cycle counts in oscillator clocks
  localparam int AND_IMMEDIATE_CYC = 2;
  localparam int SHIFT_CYC = 2;
  localparam int BIT_TEST_COMPLEMENT_CYC = 4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_COUNT = 2'h1,
    ST_READ = 2'h2,
    ST_WRITE = 2'h3
  } sbce_state_type;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_AND_IMMEDIATE = 3'h1,
    OP_ASL = 3'h2,
    OP_ASR = 3'h3,
    OP_BIT_TEST_COMPLEMENT = 3'h4
  } sbce_op_type;
endpackage

// ---- sbce_exec.sv ----
// Notes on behaviour
// - and_immediate: top byte zero, immediate bits 15:8, destination field in bits 1:0.
// - and_immediate takes two cycles and one program word.
// - and_immediate to mode_byte or operating_mode_register leaves condition flags alone.
// - arith_shift_left shifts 56 bits up, old MSB to carry, zero in.
// - arith_shift_left sets carry from old bit 55.
// - arith_shift_left sets overflow when result bit 55 changed.
// - arith_shift_left with zero shift count clears carry.
// - arith_shift_left sets limit on limited move or overflow.
// - Both shifts: negative from result bit 55, zero when result is zero.
// - Both shifts: extension and unnormalized flags follow the scaling mode.
// - arith_shift_right shifts down, keeps MSB, old bit 0 to carry.
// - arith_shift_right clears overflow; limit only from a limited move.
// - Shifts take two cycles plus move overhead.
// - bit_test_complement copies bit 0..23 to carry then inverts it, on destinations other than status_register.
// - bit_test_complement off status_register reads then writes with the bus held between.
// - On status_register, a flag in bits 0..6 changes only when selected.
// - On status_register, mode bits 8..11, 13, 15 change only when selected.
// - Other destinations: carry is the tested bit, other flags unchanged.
// - and_immediate ANDs the immediate into the chosen control register.
// - and_immediate to condition_code_byte clears flags where immediate bits are zero.
`timescale 1ns/1ns
module sbce_exec #(
  parameter logic [5:0] SR_REG_CODE = 6'h39 // Register-form code of status_register
) (
  input wire logic clk_sys, // 125 MHz clock
  input wire logic srst, // Synchronous reset
  input wire logic instr_valid, // Instruction offered
  input wire logic [23:0] instr_word, // Opcode word
  output logic instr_ready, // Idle, offer is taken
  output logic instr_done, // One-cycle completion pulse
  output logic instr_illegal, // One-cycle pulse, no effect
  input wire logic [3:0] move_cycles, // Parallel move overhead
  input wire logic move_limited, // Parallel move limited its data
  input wire logic shift_count_zero, // Zero shift count on left shift
  input wire logic acc_load_en, // Load an accumulator
  input wire logic acc_load_sel, // 0 first, 1 second accumulator
  input wire logic [55:0] acc_load_data, // Load value
  input wire logic sr_load_en, // Load status_register
  input wire logic [15:0] sr_load_data, // Load value
  input wire logic omr_load_en, // Load operating_mode_register
  input wire logic [7:0] omr_load_data, // Load value
  output logic [55:0] acc_a, // First accumulator
  output logic [55:0] acc_b, // Second accumulator
  output logic [15:0] status_reg, // status_register
  output logic [7:0] op_mode_reg, // operating_mode_register
  output logic dst_rd_req, // Destination read request
  output logic dst_wr_req, // Destination write request
  output logic [5:0] dst_field, // Address or register field
  output logic [1:0] dst_form, // Opcode bits 15:14
  output logic dst_space, // Memory space select
  output logic [23:0] dst_wdata, // Write data
  input wire logic [23:0] dst_rdata, // Read data, valid with ack
  input wire logic dst_ack, // Access accepted
  output logic bus_lock // Bus held for read-modify-write
);
  sbce_pkg::sbce_state_type state;
  sbce_pkg::sbce_op_type cur_op;
  sbce_pkg::sbce_op_type dec_op;
  logic [23:0] cur_word, rd_data;
  logic [sbce_pkg::CNT_W-1:0] cnt;
  logic cur_zero, accept, commit, bit_test_complement_sr;
  logic [55:0] acc_sel, shift_res;
  logic [15:0] next_sr, bit_test_complement_sr_mask;
  logic [4:0] bit_num;
  logic [1:0] scl;

  // Decode one opcode word into an operation
  function automatic sbce_pkg::sbce_op_type sbce_decode(input logic [23:0] w);
    sbce_decode = sbce_pkg::OP_NONE;
    if (w[23:16] == sbce_pkg::AND_IMMEDIATE_TOP && w[7:2] == sbce_pkg::AND_IMMEDIATE_LOW &&
        w[1:0] != 2'h3) begin
      sbce_decode = sbce_pkg::OP_AND_IMMEDIATE;
    end else if (w[7:4] == sbce_pkg::ASL_CODE && w[2:0] == sbce_pkg::SHIFT_LOW) begin
      sbce_decode = sbce_pkg::OP_ASL;
    end else if (w[7:4] == sbce_pkg::ASR_CODE && w[2:0] == sbce_pkg::SHIFT_LOW) begin
      sbce_decode = sbce_pkg::OP_ASR;
    end else if (w[23:16] == sbce_pkg::BIT_TEST_COMPLEMENT_TOP && !w[7] && !w[5] && w[4:0] <= sbce_pkg::BIT_MAX) begin
      sbce_decode = sbce_pkg::OP_BIT_TEST_COMPLEMENT;
    end
  endfunction

  // Extension and unnormalized flags; k is the lowest integer bit for the scaling mode
  function automatic logic [1:0] sbce_eu(input logic [55:0] r, input logic [1:0] mode);
    int k;
    logic signed [55:0] s;
    logic [55:0] t;
    k = sbce_pkg::SCL_NONE;
    if (mode == 2'h1) begin
      k = sbce_pkg::SCL_DOWN;
    end else if (mode == 2'h2) begin
      k = sbce_pkg::SCL_UP;
    end
    s = r;
    t = s >>> k;
    sbce_eu = {(t != '0) && (t != '1), r[k] == r[k-1]};
  endfunction

  assign dec_op = sbce_decode(instr_word);
  assign instr_ready = (state == sbce_pkg::ST_IDLE);
  assign accept = instr_ready && instr_valid;
  assign commit = (state == sbce_pkg::ST_COUNT) && (cnt == '0);
  assign bit_num = cur_word[4:0];
  assign bit_test_complement_sr = (cur_word[15:14] == sbce_pkg::BIT_TEST_COMPLEMENT_REG_FORM) &&
                   (cur_word[13:8] == SR_REG_CODE);
  assign bit_test_complement_sr_mask = (16'h0001 << bit_num) & sbce_pkg::SR_IMPL;
  assign scl = {status_reg[sbce_pkg::SR_S1], status_reg[sbce_pkg::SR_S0]};
  assign acc_sel = cur_word[sbce_pkg::SHIFT_ACC_BIT] ? acc_b : acc_a;

  // Shift result for either direction
  always_comb begin
    shift_res = acc_sel;
    if (cur_op == sbce_pkg::OP_ASL && !cur_zero) begin
      shift_res = {acc_sel[sbce_pkg::ACC_NMSB:0], 1'b0};
    end else if (cur_op == sbce_pkg::OP_ASR) begin
      shift_res = {acc_sel[sbce_pkg::ACC_MSB], acc_sel[sbce_pkg::ACC_MSB:1]};
    end
  end

  // Sequencer: fixed counts for register work, handshakes for destination access
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= sbce_pkg::ST_IDLE;
      cnt <= '0;
    end else begin
      case (state)
        sbce_pkg::ST_IDLE: begin
          if (accept && dec_op == sbce_pkg::OP_AND_IMMEDIATE) begin
            state <= sbce_pkg::ST_COUNT;
            cnt <= sbce_pkg::CNT_W'(sbce_pkg::AND_IMMEDIATE_CYC - 2);
          end else if (accept && (dec_op == sbce_pkg::OP_ASL || dec_op == sbce_pkg::OP_ASR)) begin
            state <= sbce_pkg::ST_COUNT;
            cnt <= sbce_pkg::CNT_W'(sbce_pkg::SHIFT_CYC - 2) + sbce_pkg::CNT_W'(move_cycles);
          end else if (accept && dec_op == sbce_pkg::OP_BIT_TEST_COMPLEMENT) begin
            if (instr_word[15:14] == sbce_pkg::BIT_TEST_COMPLEMENT_REG_FORM &&
                instr_word[13:8] == SR_REG_CODE) begin
              state <= sbce_pkg::ST_COUNT;
              cnt <= sbce_pkg::CNT_W'(sbce_pkg::BIT_TEST_COMPLEMENT_CYC - 2);
            end else begin
              state <= sbce_pkg::ST_READ;
            end
          end
        end
        sbce_pkg::ST_COUNT: begin
          if (cnt == '0) begin
            state <= sbce_pkg::ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        sbce_pkg::ST_READ: begin
          if (dst_ack) begin
            state <= sbce_pkg::ST_WRITE;
          end
        end
        sbce_pkg::ST_WRITE: begin
          if (dst_ack) begin
            state <= sbce_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= sbce_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Latch the instruction being worked on
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cur_op <= sbce_pkg::OP_NONE;
      cur_word <= 24'h000000;
      cur_zero <= 1'b0;
    end else if (accept) begin
      cur_op <= dec_op;
      cur_word <= instr_word;
      cur_zero <= shift_count_zero;
    end
  end

  // Read data captured for the write-back
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data <= 24'h000000;
    end else if (state == sbce_pkg::ST_READ && dst_ack) begin
      rd_data <= dst_rdata;
    end
  end

  // Destination port; the lock spans both accesses so no other master slips in
  assign dst_rd_req = (state == sbce_pkg::ST_READ);
  assign dst_wr_req = (state == sbce_pkg::ST_WRITE);
  assign bus_lock = dst_rd_req || dst_wr_req;
  assign dst_field = cur_word[13:8];
  assign dst_form = cur_word[15:14];
  assign dst_space = cur_word[sbce_pkg::BIT_TEST_COMPLEMENT_SPACE_BIT];
  assign dst_wdata = rd_data ^ (24'h000001 << bit_num);

  // Next status_register value for the committing instruction
  always_comb begin
    logic [1:0] eu;
    logic ovf;
    eu = sbce_eu(shift_res, scl);
    ovf = acc_sel[sbce_pkg::ACC_MSB] ^ acc_sel[sbce_pkg::ACC_NMSB];
    next_sr = status_reg;
    if (commit && cur_op == sbce_pkg::OP_AND_IMMEDIATE) begin
      if (cur_word[1:0] == sbce_pkg::DST_CCR) begin
        next_sr[7:0] = status_reg[7:0] & cur_word[15:8];
      end else if (cur_word[1:0] == sbce_pkg::DST_MODE) begin
        next_sr[15:8] = status_reg[15:8] & cur_word[15:8];
      end
    end else if (commit && (cur_op == sbce_pkg::OP_ASL || cur_op == sbce_pkg::OP_ASR)) begin
      next_sr[sbce_pkg::SR_N] = shift_res[sbce_pkg::ACC_MSB];
      next_sr[sbce_pkg::SR_Z] = (shift_res == '0);
      next_sr[sbce_pkg::SR_E] = eu[1];
      next_sr[sbce_pkg::SR_U] = eu[0];
      if (cur_op == sbce_pkg::OP_ASL) begin
        next_sr[sbce_pkg::SR_C] = !cur_zero && acc_sel[sbce_pkg::ACC_MSB];
        next_sr[sbce_pkg::SR_V] = !cur_zero && ovf;
        next_sr[sbce_pkg::SR_L] = status_reg[sbce_pkg::SR_L] | move_limited |
                                  (!cur_zero && ovf);
      end else begin
        next_sr[sbce_pkg::SR_C] = acc_sel[0];
        next_sr[sbce_pkg::SR_V] = 1'b0;
        next_sr[sbce_pkg::SR_L] = status_reg[sbce_pkg::SR_L] | move_limited;
      end
    end else if (commit && cur_op == sbce_pkg::OP_BIT_TEST_COMPLEMENT && bit_test_complement_sr) begin
      next_sr = status_reg ^ bit_test_complement_sr_mask;
    end else if (state == sbce_pkg::ST_WRITE && dst_ack) begin
      next_sr[sbce_pkg::SR_C] = rd_data[bit_num];
    end else if (instr_ready && !instr_valid && sr_load_en) begin
      next_sr = sr_load_data & sbce_pkg::SR_IMPL;
    end
  end

  // Status register; outside loads only while idle so flags cannot race an instruction
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_reg <= sbce_pkg::SR_RESET;
    end else begin
      status_reg <= next_sr;
    end
  end

  // Operating mode register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      op_mode_reg <= sbce_pkg::OMR_RESET;
    end else if (commit && cur_op == sbce_pkg::OP_AND_IMMEDIATE && cur_word[1:0] == sbce_pkg::DST_OMR) begin
      op_mode_reg <= op_mode_reg & cur_word[15:8];
    end else if (instr_ready && !instr_valid && omr_load_en) begin
      op_mode_reg <= omr_load_data;
    end
  end

  // Accumulators
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_a <= '0;
      acc_b <= '0;
    end else if (commit && (cur_op == sbce_pkg::OP_ASL || cur_op == sbce_pkg::OP_ASR)) begin
      if (cur_word[sbce_pkg::SHIFT_ACC_BIT]) begin
        acc_b <= shift_res;
      end else begin
        acc_a <= shift_res;
      end
    end else if (instr_ready && !instr_valid && acc_load_en) begin
      if (acc_load_sel) begin
        acc_b <= acc_load_data;
      end else begin
        acc_a <= acc_load_data;
      end
    end
  end

  // Completion and refusal pulses
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      instr_done <= 1'b0;
      instr_illegal <= 1'b0;
    end else begin
      instr_done <= commit || (state == sbce_pkg::ST_WRITE && dst_ack);
      instr_illegal <= accept && dec_op == sbce_pkg::OP_NONE;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_AND_IMMEDIATE_TWO: assert property (accept && dec_op == sbce_pkg::OP_AND_IMMEDIATE |-> ##1 commit ##1 instr_done)
    else $error("and_immediate not two cycles");
  AST_AND_IMMEDIATE_NOFLAG: assert property (commit && cur_op == sbce_pkg::OP_AND_IMMEDIATE && cur_word[1:0] != sbce_pkg::DST_CCR |=> status_reg[6:0] == $past(status_reg[6:0]))
    else $error("flags moved on control AND");
  AST_CCR_AND: assert property (commit && cur_op == sbce_pkg::OP_AND_IMMEDIATE && cur_word[1:0] == sbce_pkg::DST_CCR |=> status_reg[6:0] == ($past(status_reg[6:0]) & $past(cur_word[14:8])))
    else $error("condition byte AND wrong");
  AST_ASL_CARRY: assert property (commit && cur_op == sbce_pkg::OP_ASL && !cur_zero |=> status_reg[sbce_pkg::SR_C] == $past(acc_sel[sbce_pkg::ACC_MSB]))
    else $error("left shift carry wrong");
  AST_ASL_OVF: assert property (commit && cur_op == sbce_pkg::OP_ASL && !cur_zero |=> status_reg[sbce_pkg::SR_V] == ($past(acc_sel[sbce_pkg::ACC_MSB]) != $past(acc_sel[sbce_pkg::ACC_NMSB])))
    else $error("left shift overflow wrong");
  AST_ASL_ZERO: assert property (commit && cur_op == sbce_pkg::OP_ASL && cur_zero |=> !status_reg[sbce_pkg::SR_C])
    else $error("zero count left carry set");
  AST_ASL_LIMIT: assert property (commit && cur_op == sbce_pkg::OP_ASL && (move_limited || (!cur_zero && acc_sel[sbce_pkg::ACC_MSB] != acc_sel[sbce_pkg::ACC_NMSB])) |=> status_reg[sbce_pkg::SR_L])
    else $error("left shift limit not set");
  AST_ASR: assert property (commit && cur_op == sbce_pkg::OP_ASR |=> !status_reg[sbce_pkg::SR_V] && status_reg[sbce_pkg::SR_C] == $past(acc_sel[0]))
    else $error("right shift flags wrong");
  AST_NZ: assert property (commit && cur_op inside {sbce_pkg::OP_ASL, sbce_pkg::OP_ASR} |=> status_reg[sbce_pkg::SR_N] == $past(shift_res[sbce_pkg::ACC_MSB]) && status_reg[sbce_pkg::SR_Z] == ($past(shift_res) == '0))
    else $error("shift N or Z wrong");
  AST_LOCK: assert property (dst_rd_req && dst_ack |=> bus_lock && dst_wr_req)
    else $error("bus released between accesses");
  AST_BIT_TEST_COMPLEMENT_OTHER: assert property (dst_wr_req && dst_ack |=> status_reg[sbce_pkg::SR_C] == $past(rd_data[bit_num]) && status_reg[6:1] == $past(status_reg[6:1]))
    else $error("bit change flags wrong");
  AST_BIT_TEST_COMPLEMENT_SR: assert property (commit && cur_op == sbce_pkg::OP_BIT_TEST_COMPLEMENT |=> (status_reg ^ $past(status_reg)) == $past(bit_test_complement_sr_mask))
    else $error("status bit change touched other bits");

  COV_AND_IMMEDIATE_CCR: cover property (commit && cur_op == sbce_pkg::OP_AND_IMMEDIATE && cur_word[1:0] == sbce_pkg::DST_CCR);
  COV_ASL_OVF: cover property (commit && cur_op == sbce_pkg::OP_ASL && next_sr[sbce_pkg::SR_V]);
  COV_ASR: cover property (commit && cur_op == sbce_pkg::OP_ASR);
  COV_BIT_TEST_COMPLEMENT_MEM: cover property (dst_rd_req ##[1:8] dst_wr_req && dst_ack);
endmodule

// ---- sbce_exec_bench.sv ----
`timescale 1ns/1ns
module sbce_exec_bench;
  typedef struct {
    logic [55:0] a;
    logic [55:0] b;
    logic [15:0] s;
    logic [7:0] o;
    logic ill;
    int lat;
  } sbce_note_type;
  localparam logic [5:0] SR_CODE = 6'h39;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic instr_valid = 1'b0;
  logic [23:0] instr_word = 24'h000000;
  logic [3:0] move_cycles = 4'h0;
  logic move_limited = 1'b0;
  logic shift_count_zero = 1'b0;
  logic acc_load_en = 1'b0;
  logic acc_load_sel = 1'b0;
  logic [55:0] acc_load_data = 56'h0;
  logic sr_load_en = 1'b0;
  logic [15:0] sr_load_data = 16'h0000;
  logic omr_load_en = 1'b0;
  logic [7:0] omr_load_data = 8'h00;
  logic [23:0] dst_rdata = 24'h000000;
  logic dst_ack = 1'b0;
  logic instr_ready, instr_done, instr_illegal, dst_rd_req, dst_wr_req, dst_space, bus_lock;
  logic [55:0] acc_a, acc_b;
  logic [15:0] status_reg;
  logic [7:0] op_mode_reg;
  logic [5:0] dst_field;
  logic [1:0] dst_form;
  logic [23:0] dst_wdata;
  sbce_note_type note_q[$];
  int acc_q[$];
  int cyc = 0;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h5664233E;
  // Bench copy of the architectural state
  logic [55:0] ma = 56'h0;
  logic [55:0] mb = 56'h0;
  logic [15:0] ms = 16'h0000;
  logic [7:0] mo = 8'h00;
  // Memory responder state
  logic [23:0] mem_val = 24'h000000;
  int mem_bit = 0;
  logic [5:0] exp_field = 6'h00;
  logic [1:0] exp_form = 2'h0;
  logic exp_space = 1'b0;
  int wr_ack_cyc = 0;
  int wait_cnt = 0;
  logic rd_done = 1'b0;

  sbce_exec #(.SR_REG_CODE(SR_CODE)) sbce_exec_i (
    .clk_sys(clk_sys), .srst(srst), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .instr_done(instr_done), .instr_illegal(instr_illegal),
    .move_cycles(move_cycles), .move_limited(move_limited), .shift_count_zero(shift_count_zero),
    .acc_load_en(acc_load_en), .acc_load_sel(acc_load_sel), .acc_load_data(acc_load_data),
    .sr_load_en(sr_load_en), .sr_load_data(sr_load_data), .omr_load_en(omr_load_en),
    .omr_load_data(omr_load_data), .acc_a(acc_a), .acc_b(acc_b), .status_reg(status_reg),
    .op_mode_reg(op_mode_reg), .dst_rd_req(dst_rd_req), .dst_wr_req(dst_wr_req),
    .dst_field(dst_field), .dst_form(dst_form), .dst_space(dst_space), .dst_wdata(dst_wdata),
    .dst_rdata(dst_rdata), .dst_ack(dst_ack), .bus_lock(bus_lock)
  );

  // 125 MHz clock and edge counter
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Flags E, U, N, Z; the E/U boundary moves with the scaling bits
  function automatic logic [3:0] nzeu(input logic [55:0] r, input logic [15:0] s);
    int k;
    logic e;
    k = s[10] ? sbce_pkg::SCL_DOWN : (s[11] ? sbce_pkg::SCL_UP : sbce_pkg::SCL_NONE);
    e = 1'b0;
    for (int j = k; j < 55; j++) if (r[j] != r[55]) e = 1'b1;
    return {e, r[k] == r[k-1], r[55], r == 56'h0};
  endfunction

  task automatic chk(input string nm, input logic [55:0] exp, input logic [55:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Offer a word and note the expected outcome; the offer stays up for back-to-back use
  task automatic issue(input logic [23:0] w, input int lat, input logic ill);
    int i;
    sbce_note_type n;
    n.a = ma; n.b = mb; n.s = ms; n.o = mo; n.ill = ill; n.lat = lat;
    note_q.push_back(n);
    instr_valid <= 1'b1;
    instr_word <= w;
    i = 0;
    do begin @(posedge clk_sys); i++; end while (instr_ready !== 1'b1 && i < 100);
    acc_q.push_back(cyc);
    // A stuck offer counts against the run
    if (instr_ready !== 1'b1) begin
      n_mismatch++;
      $display("mismatch instr_ready expected 1 seen 0");
    end
  endtask

  // Drop the offer and let everything in flight finish
  task automatic idle();
    int i;
    instr_valid <= 1'b0;
    i = 0;
    do begin @(posedge clk_sys); i++; end
    while ((instr_ready !== 1'b1 || note_q.size() != 0) && i < 100);
    // Work that never drains counts against the run
    if (instr_ready !== 1'b1 || note_q.size() != 0) begin
      n_mismatch++;
      $display("mismatch drain expected idle seen busy");
    end
  endtask

  // Loads only act when idle with no offer, so idle first
  task automatic load(input logic [55:0] a, input logic [55:0] b, input logic [15:0] s,
                      input logic [7:0] o);
    idle();
    acc_load_en <= 1'b1; acc_load_sel <= 1'b0; acc_load_data <= a;
    sr_load_en <= 1'b1; sr_load_data <= s; omr_load_en <= 1'b1; omr_load_data <= o;
    @(posedge clk_sys);
    acc_load_sel <= 1'b1; acc_load_data <= b; sr_load_en <= 1'b0; omr_load_en <= 1'b0;
    @(posedge clk_sys);
    acc_load_en <= 1'b0;
    ma = a; mb = b; ms = s & sbce_pkg::SR_IMPL; mo = o;
    @(posedge clk_sys);
    chk("acc_a", ma, acc_a);
    chk("acc_b", mb, acc_b);
    chk("status_reg", 56'(ms), 56'(status_reg));
    chk("op_mode_reg", 56'(mo), 56'(op_mode_reg));
  endtask

  // Result monitor: oldest note against each completion
  always @(posedge clk_sys) begin
    sbce_note_type n;
    int t;
    if (srst === 1'b0 && (instr_done === 1'b1 || instr_illegal === 1'b1)) begin
      if (note_q.size() == 0) begin
        n_mismatch++;
        $display("mismatch completion expected none seen one");
      end else begin
        n = note_q.pop_front();
        t = acc_q.pop_front();
        chk("instr_illegal", 56'(n.ill), 56'(instr_illegal));
        chk("latency", 56'(n.lat < 0 ? wr_ack_cyc + 1 : t + n.lat), 56'(cyc));
        chk("acc_a", n.a, acc_a);
        chk("acc_b", n.b, acc_b);
        chk("status_reg", 56'(n.s), 56'(status_reg));
        chk("op_mode_reg", 56'(n.o), 56'(op_mode_reg));
      end
    end
  end

  // Destination memory with random wait states; data lines scrambled outside the ack cycle
  always @(posedge clk_sys) begin
    dst_ack <= 1'b0;
    dst_rdata <= ~mem_val;
    if (dst_rd_req === 1'b1 || dst_wr_req === 1'b1) chk("bus_lock", 56'h1, 56'(bus_lock));
    if (rd_done) chk("dst_wr_req", 56'h1, 56'(dst_wr_req));
    rd_done = 1'b0;
    if (dst_ack === 1'b1 && dst_rd_req === 1'b1) begin
      rd_done = 1'b1;
      chk("dst_field", 56'(exp_field), 56'(dst_field));
      chk("dst_form", 56'(exp_form), 56'(dst_form));
      chk("dst_space", 56'(exp_space), 56'(dst_space));
    end else if (dst_ack === 1'b1 && dst_wr_req === 1'b1) begin
      wr_ack_cyc = cyc;
      chk("dst_wdata", 56'(mem_val ^ (24'h000001 << mem_bit)), 56'(dst_wdata));
    end else if (dst_rd_req === 1'b1 || dst_wr_req === 1'b1) begin
      if (wait_cnt > 0) wait_cnt = wait_cnt - 1;
      else begin
        dst_ack <= 1'b1;
        dst_rdata <= mem_val;
        wait_cnt = int'(rnd() % 3);
      end
    end
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  initial begin
    logic [7:0] imm;
    logic [55:0] old, r;
    logic [3:0] f;
    logic arith_shift_left, sel, lim, z, c, v, l, sp;
    logic [3:0] m;
    logic [1:0] fm;
    logic [5:0] fd;
    logic [4:0] bn;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("status_reg", 56'(sbce_pkg::SR_RESET), 56'(status_reg)); // RESET
    chk("op_mode_reg", 56'(sbce_pkg::OMR_RESET), 56'(op_mode_reg)); // RESET
    chk("acc_a", 56'h0, acc_a); // RESET
    chk("instr_ready", 56'h1, 56'(instr_ready)); // RESET
    // Every destination code, offered back to back
    for (int rd = 0; rd < 3; rd++) begin
      load(56'(rnd()), 56'(rnd()), 16'(rnd()), 8'(rnd()));
      for (int d = 0; d < 4; d++) begin
        imm = 8'(rnd());
        if (d == 0) ms[15:8] = ms[15:8] & imm;
        if (d == 1) ms[7:0] = ms[7:0] & imm;
        if (d == 2) mo = mo & imm;
        issue({8'h00, imm, sbce_pkg::AND_IMMEDIATE_LOW, 2'(d)}, d == 3 ? 1 : sbce_pkg::AND_IMMEDIATE_CYC, d == 3);
      end
    end
    // Accumulator shifts over all three scaling modes
    for (int i = 0; i < 48; i++) begin
      if (i % 4 == 0) begin
        old = (i == 4) ? 56'h80000000000000 : 56'({rnd(), rnd()});
        load(old, 56'({rnd(), rnd()}), (16'(rnd()) & 16'hF3FF) | (16'((i / 4) % 3) << 10),
             8'(rnd()));
      end
      arith_shift_left = rnd() % 2; sel = rnd() % 2; m = 4'(rnd() % 4); lim = rnd() % 2;
      z = arith_shift_left && (rnd() % 5 == 0);
      old = sel ? mb : ma;
      l = ms[6] | lim;
      if (arith_shift_left && z) begin r = old; c = 1'b0; v = 1'b0; end
      else if (arith_shift_left) begin r = {old[54:0], 1'b0}; c = old[55]; v = r[55] ^ old[55]; end
      else begin r = {old[55], old[55:1]}; c = old[0]; v = 1'b0; end
      l = l | v;
      f = nzeu(r, ms);
      ms[6:0] = {l, f, v, c};
      if (sel) mb = r;
      else ma = r;
      move_cycles <= m; move_limited <= lim; shift_count_zero <= z;
      issue({16'(rnd()) | 16'h8000, arith_shift_left ? sbce_pkg::ASL_CODE : sbce_pkg::ASR_CODE, sel,
             sbce_pkg::SHIFT_LOW}, sbce_pkg::SHIFT_CYC + int'(m), 1'b0);
      idle();
    end
    // Bit change on status_register, every bit position including reserved ones
    for (int b = 0; b < 24; b++) begin
      load(ma, mb, 16'(rnd()), mo);
      if (b < 16 && sbce_pkg::SR_IMPL[b]) ms[b] = ~ms[b];
      issue({sbce_pkg::BIT_TEST_COMPLEMENT_TOP, 2'h3, SR_CODE, 3'h2, 5'(b)}, sbce_pkg::BIT_TEST_COMPLEMENT_CYC, 1'b0);
    end
    // Bit change through the destination port, all forms
    for (int i = 0; i < 12; i++) begin
      idle();
      fm = 2'(i % 4); fd = 6'(rnd()); sp = rnd() % 2; bn = 5'(rnd() % 24);
      if (fm == 2'h3 && fd == SR_CODE) fd = fd ^ 6'h01;
      if (fm == 2'h3) sp = 1'b1;
      mem_val = 24'(rnd()); mem_bit = bn;
      exp_field = fd; exp_form = fm; exp_space = sp;
      ms[0] = mem_val[bn];
      issue({sbce_pkg::BIT_TEST_COMPLEMENT_TOP, fm, fd, 1'b0, sp, 1'b0, bn}, -1, 1'b0);
    end
    // Bit number beyond 23 has no effect
    idle();
    issue({sbce_pkg::BIT_TEST_COMPLEMENT_TOP, 2'h0, 6'h05, 3'h0, 5'(24 + rnd() % 8)}, 1, 1'b1);
    idle();
    summarize();
  end
endmodule
